/* include/vxc_pkg.sv */
// Constants and types for the sequencer extension register group
package vxc_pkg;

	localparam logic [15:0] VXC_PORT_INDEX = 16'h03C4;
	localparam logic [15:0] VXC_PORT_DATA  = 16'h03C5;

	localparam logic [7:0] VXC_IDX_BANDWIDTH = 8'h86;
	localparam logic [7:0] VXC_IDX_ROM       = 8'h87;
	localparam logic [7:0] VXC_IDX_PRESET    = 8'h88;
	localparam logic [7:0] VXC_IDX_FONT      = 8'h89;
	localparam logic [7:0] VXC_IDX_PANEL     = 8'h8A;

	localparam logic [7:0] VXC_RST_BANDWIDTH = 8'h00;
	localparam logic [7:0] VXC_RST_ROM       = 8'h00;
	localparam logic [7:0] VXC_RST_PRESET    = 8'h00;
	localparam logic [7:0] VXC_RST_FONT      = 8'h00;
	localparam logic [7:0] VXC_RST_PANEL     = 8'h03;
	localparam logic [7:0] VXC_RST_INDEX     = 8'h00;

	// Writable bits; bits outside each mask read back as zero (panel bit 5 is writable though unused)
	localparam logic [7:0] VXC_MASK_BANDWIDTH = 8'h37;
	localparam logic [7:0] VXC_MASK_ROM       = 8'h80;
	localparam logic [7:0] VXC_MASK_PRESET    = 8'h1F;
	localparam logic [7:0] VXC_MASK_FONT      = 8'h7F;
	localparam logic [7:0] VXC_MASK_PANEL     = 8'hFF;

	localparam int VXC_BW_CGA_MGA_COMPAT_STATE_LSB     = 4;
	localparam int VXC_BW_EGA_LSB      = 0;
	localparam int VXC_ROM_DISABLE_BIT = 7;
	localparam int VXC_FONT_PLANE3_BIT = 6;
	localparam int VXC_FONT_VSYNC_BIT  = 5;
	localparam int VXC_FONT_HSYNC_BIT  = 4;
	localparam int VXC_FONT_POS_BIT    = 3;
	localparam int VXC_FONT_PTR_LSB    = 0;
	localparam int VXC_PANEL_PSAVE_BIT = 7;
	localparam int VXC_PANEL_EIGHT_BIT = 6;
	localparam int VXC_PANEL_DIV2_BIT  = 4;
	localparam int VXC_PANEL_XTAL_BIT  = 3;
	localparam int VXC_PANEL_PAGE_LSB  = 0;
	localparam int VXC_SEQ_EIGHT_BIT   = 0;
	localparam int VXC_SEQ_HALF_BIT    = 1;

	localparam logic [1:0] VXC_ROM_TOP_BLOCK = 2'h3;
	localparam logic [3:0] VXC_REFRESH_CYCLES = 4'h5;
	localparam logic [3:0] VXC_POINTER_CYCLES = 4'h2;
	localparam logic [1:0] VXC_FONT_PLANE_NORMAL = 2'h2;
	localparam logic [1:0] VXC_FONT_PLANE_ALT    = 2'h3;

	typedef enum logic [5:0] {
		VXC_IL_1_1  = 6'h01,
		VXC_IL_1_2  = 6'h02,
		VXC_IL_1_4  = 6'h04,
		VXC_IL_1_7  = 6'h08,
		VXC_IL_3_2  = 6'h10,
		VXC_IL_RSVD = 6'h20
	} vxc_il_t;

	typedef enum logic [2:0] {
		VXC_ST_DISP    = 3'h1,
		VXC_ST_REFRESH = 3'h2,
		VXC_ST_POINTER = 3'h4
	} vxc_arb_st_t;

endpackage

/* hw/vxc_mem_arbiter.sv */
// Video memory cycle allocation between processor, display, refresh, pointer
`timescale 1ns/1ps
module vxc_mem_arbiter (
	input  wire logic            clk,
	input  wire logic            srst,
	input  wire logic            ce,
	input  vxc_pkg::vxc_il_t     il,
	input  wire logic            hretrace,
	input  wire logic            vretrace,
	input  wire logic            video_on,
	input  wire logic            pointer_en,
	input  wire logic            power_save,
	output logic                 slot_cpu_q,
	output logic                 slot_crt_q,
	output logic                 slot_refresh_q,
	output logic                 slot_pointer_q
);

	vxc_pkg::vxc_arb_st_t st_q, st_d;
	logic [3:0] cnt_q, cnt_d, ph_q, cpu_n, crt_n, last_ph;
	logic       hr_q;
	wire        hr_rise = hretrace & ~hr_q;
	wire        blank = hretrace | vretrace | ~video_on;
	wire        disp_d = (st_d == vxc_pkg::VXC_ST_DISP);
	wire        cpu_turn = (ph_q < cpu_n);

	assign cpu_n = (il == vxc_pkg::VXC_IL_3_2) ? 4'h3 : 4'h1;
	assign crt_n = (il == vxc_pkg::VXC_IL_1_1) ? 4'h1 :
		(il == vxc_pkg::VXC_IL_1_2) ? 4'h2 :
		(il == vxc_pkg::VXC_IL_1_7) ? 4'h7 :
		(il == vxc_pkg::VXC_IL_3_2) ? 4'h2 : 4'h4;
	assign last_ph = cpu_n + crt_n - 4'h1;

	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		case (st_q)
			vxc_pkg::VXC_ST_DISP:
			begin
				if (hr_rise)
				begin
					st_d = vxc_pkg::VXC_ST_REFRESH;
					cnt_d = vxc_pkg::VXC_REFRESH_CYCLES - 4'h1;
				end
			end
			vxc_pkg::VXC_ST_REFRESH:
			begin
				if (cnt_q != 4'h0)
					cnt_d = cnt_q - 4'h1;
				else if (pointer_en & ~power_save)
				begin
					st_d = vxc_pkg::VXC_ST_POINTER;
					cnt_d = vxc_pkg::VXC_POINTER_CYCLES - 4'h1;
				end
				else
					st_d = vxc_pkg::VXC_ST_DISP;
			end
			vxc_pkg::VXC_ST_POINTER:
			begin
				if (cnt_q != 4'h0)
					cnt_d = cnt_q - 4'h1;
				else
					st_d = vxc_pkg::VXC_ST_DISP;
			end
			default:
			begin
				st_d = vxc_pkg::VXC_ST_DISP;
				cnt_d = 4'h0;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_q <= vxc_pkg::VXC_ST_DISP;
			cnt_q <= 4'h0;
			ph_q <= 4'h0;
			hr_q <= 1'b0;
			slot_cpu_q <= 1'b0;
			slot_crt_q <= 1'b0;
			slot_refresh_q <= 1'b0;
			slot_pointer_q <= 1'b0;
		end
		else if (ce)
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			hr_q <= hretrace;
			ph_q <= (disp_d & ~blank & (ph_q < last_ph)) ? ph_q + 4'h1 : 4'h0;
			// outside power save, blanking gives processor every cycle outside refresh and pointer slots
			slot_cpu_q <= ~power_save & disp_d & (blank | cpu_turn);
			slot_crt_q <= ~power_save & disp_d & ~blank & ~cpu_turn;
			slot_refresh_q <= (st_d == vxc_pkg::VXC_ST_REFRESH);
			slot_pointer_q <= (st_d == vxc_pkg::VXC_ST_POINTER);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst || !ce);

	sequence s_busy14;
		il == vxc_pkg::VXC_IL_1_4 && !blank && !power_save
			&& st_q == vxc_pkg::VXC_ST_DISP;
	endsequence

	a_refresh_five: assert property (
		hr_rise && st_q == vxc_pkg::VXC_ST_DISP
			|=> slot_refresh_q[*5] ##1 !slot_refresh_q)
		else $error("refresh burst is not five cycles");

	a_pointer_two: assert property (
		$rose(slot_pointer_q) |-> $past(slot_refresh_q)
			##0 slot_pointer_q[*2] ##1 !slot_pointer_q)
		else $error("pointer burst is not two cycles after refresh");

	a_retrace_cpu: assert property (
		st_q == vxc_pkg::VXC_ST_DISP && vretrace && !hr_rise && !power_save
			|=> slot_cpu_q && !slot_crt_q)
		else $error("retrace cycle not given to processor");

	a_one_in_five: assert property (
		s_busy14 ##1 slot_cpu_q ##0 s_busy14[*5]
			|=> slot_cpu_q && $past(slot_crt_q, 4) && $past(slot_crt_q))
		else $error("1:4 interleave pattern broken");

endmodule

/* hw/vxc_font_addr.sv */
// Compatibility font byte address and plane selection
`timescale 1ns/1ps
module vxc_font_addr (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       ce,
	input  wire logic [7:0] char_code,
	input  wire logic [4:0] scan_row,
	input  wire logic [2:0] font_ptr,
	input  wire logic       font_pos,
	input  wire logic       plane3,
	output logic      [15:0] font_addr_q,
	output logic      [1:0] font_plane_q
);

	// downward fetch starts at byte 31
	wire [4:0] row_byte = font_pos ? ~scan_row : scan_row;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			font_addr_q <= 16'h0000;
			font_plane_q <= vxc_pkg::VXC_FONT_PLANE_NORMAL;
		end
		else if (ce)
		begin
			font_addr_q <= {font_ptr, char_code, row_byte};
			font_plane_q <= plane3 ? vxc_pkg::VXC_FONT_PLANE_ALT
				: vxc_pkg::VXC_FONT_PLANE_NORMAL;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst || !ce);

	a_font_down: assert property (
		font_pos |=> font_addr_q[4:0] == ~$past(scan_row)
			&& font_addr_q[12:5] == $past(char_code))
		else $error("downward font byte address wrong");

	a_font_block: assert property (
		1'b1 |=> font_addr_q[15:13] == $past(font_ptr))
		else $error("font block does not follow pointer");

	a_font_plane: assert property (
		!plane3 |=> font_plane_q == vxc_pkg::VXC_FONT_PLANE_NORMAL)
		else $error("font not taken from plane 2");

endmodule

/* hw/vxc_ext_regs.sv */
// Sequencer extension registers: bandwidth, ROM, preset row, font, panel
`timescale 1ns/1ps
module vxc_ext_regs #(
	parameter logic [5:0] FIXED_SYNC_WIDTH = 6'h0F
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        ce,
	input  wire logic [15:0] io_addr,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [7:0]  io_wdata,
	output logic      [7:0]  io_rdata_q,
	input  wire logic [7:0]  sequencer_clocking_reg,
	input  wire logic        sequencer_sync_reset_bit,
	input  wire logic        cga_mga_compat_state,
	input  wire logic        half_input_clock_mode,
	input  wire logic        hretrace,
	input  wire logic        vretrace,
	input  wire logic        video_on,
	input  wire logic        pointer_en,
	input  wire logic        bios_rd,
	input  wire logic [14:0] bios_addr,
	input  wire logic        line_start,
	input  wire logic        frame_start,
	input  wire logic [9:0]  scan_line,
	input  wire logic [9:0]  line_compare_reg,
	input  wire logic [4:0]  upper_screen_preset_row,
	input  wire logic [4:0]  cell_height,
	input  wire logic [7:0]  char_code,
	input  wire logic [7:0]  legacy_sync_width_reg,
	output logic             slot_cpu_q,
	output logic             slot_crt_q,
	output logic             slot_refresh_q,
	output logic             slot_pointer_q,
	output logic             rom_cs_q,
	output logic      [15:0] rom_addr_q,
	output logic      [4:0]  row_scan_q,
	output logic      [15:0] font_addr_q,
	output logic      [1:0]  font_plane_q,
	output logic             sync_width_prog_q,
	output logic      [5:0]  sync_width_q,
	output logic             gray_clk_en_q,
	output logic             hfb_clk_en_q,
	output logic             pclk_en_q,
	output logic             xtal_drive_q,
	output logic             nine_dot_q
);

	logic [7:0] index_q;
	logic [7:0] bandwidth_q;
	logic [7:0] rom_control_q;
	logic [7:0] preset_q;
	logic [7:0] font_control_q;
	logic [7:0] panel_control_q;
	vxc_pkg::vxc_il_t il;
	vxc_pkg::vxc_il_t il_cga_mga_compat_state;
	vxc_pkg::vxc_il_t il_ega;

	wire wr_index = io_wr & (io_addr == vxc_pkg::VXC_PORT_INDEX);
	wire wr_data  = io_wr & (io_addr == vxc_pkg::VXC_PORT_DATA);
	wire rd_index = io_rd & (io_addr == vxc_pkg::VXC_PORT_INDEX);
	wire rd_data  = io_rd & (io_addr == vxc_pkg::VXC_PORT_DATA);
	wire sel_bw    = (index_q == vxc_pkg::VXC_IDX_BANDWIDTH);
	wire sel_rom   = (index_q == vxc_pkg::VXC_IDX_ROM);
	wire sel_pre   = (index_q == vxc_pkg::VXC_IDX_PRESET);
	wire sel_font  = (index_q == vxc_pkg::VXC_IDX_FONT);
	wire sel_panel = (index_q == vxc_pkg::VXC_IDX_PANEL);
	wire sync_clr  = ~sequencer_sync_reset_bit;

	wire [7:0] rd_mux = sel_bw ? bandwidth_q :
		sel_rom ? rom_control_q :
		sel_pre ? preset_q :
		sel_font ? font_control_q :
		sel_panel ? panel_control_q : 8'h00;
	wire [7:0] rd_value = rd_index ? index_q : rd_mux;

	wire       power_save = panel_control_q[vxc_pkg::VXC_PANEL_PSAVE_BIT];
	wire       div2 = panel_control_q[vxc_pkg::VXC_PANEL_DIV2_BIT];
	wire [2:0] rom_page =
		panel_control_q[vxc_pkg::VXC_PANEL_PAGE_LSB +: 3];
	wire [1:0] bw_cga_mga_compat_state = bandwidth_q[vxc_pkg::VXC_BW_CGA_MGA_COMPAT_STATE_LSB +: 2];
	wire [2:0] bw_ega  = bandwidth_q[vxc_pkg::VXC_BW_EGA_LSB +: 3];
	wire       clk_half_sel = sequencer_clocking_reg[vxc_pkg::VXC_SEQ_HALF_BIT];

	wire nine_dot = ~sequencer_clocking_reg[vxc_pkg::VXC_SEQ_EIGHT_BIT]
		& ~panel_control_q[vxc_pkg::VXC_PANEL_EIGHT_BIT];

	assign il_cga_mga_compat_state = (bw_cga_mga_compat_state == 2'h0) ? vxc_pkg::VXC_IL_1_4 :
		(bw_cga_mga_compat_state == 2'h1) ? vxc_pkg::VXC_IL_1_1 :
		(bw_cga_mga_compat_state == 2'h3) ? (nine_dot ? vxc_pkg::VXC_IL_1_4
			: vxc_pkg::VXC_IL_1_7) : vxc_pkg::VXC_IL_RSVD;

	assign il_ega = (bw_ega == 3'h0) ? (clk_half_sel ? vxc_pkg::VXC_IL_3_2
			: vxc_pkg::VXC_IL_1_4) :
		(bw_ega == 3'h1) ? vxc_pkg::VXC_IL_1_1 :
		(bw_ega == 3'h2) ? vxc_pkg::VXC_IL_1_2 :
		(bw_ega == 3'h3) ? vxc_pkg::VXC_IL_1_7 :
		(bw_ega == 3'h4) ? vxc_pkg::VXC_IL_1_4 :
		(bw_ega == 3'h5) ? vxc_pkg::VXC_IL_3_2 : vxc_pkg::VXC_IL_RSVD;

	// bad settings are not corrected here beyond the forced cases
	assign il = !cga_mga_compat_state ? il_ega :
		half_input_clock_mode ? vxc_pkg::VXC_IL_3_2 : il_cga_mga_compat_state;

	// top 8K block takes the page
	wire       rom_top = (bios_addr[14:13] == vxc_pkg::VXC_ROM_TOP_BLOCK);
	wire [15:0] rom_addr_d = rom_top ? {rom_page, bios_addr[12:0]}
		: {1'b0, bios_addr};

	wire line_hit = line_start & (scan_line == line_compare_reg);
	wire [4:0] row_next = (row_scan_q == cell_height) ? 5'h00
		: row_scan_q + 5'h01;

	wire sync_prog = font_control_q[vxc_pkg::VXC_FONT_VSYNC_BIT]
		| font_control_q[vxc_pkg::VXC_FONT_HSYNC_BIT];

	always_ff @(posedge clk)
	begin
		if (srst)
			index_q <= vxc_pkg::VXC_RST_INDEX;
		else if (ce && wr_index)
			index_q <= io_wdata;
	end

	// Bandwidth selection also clears on sequencer sync reset
	always_ff @(posedge clk)
	begin
		if (srst || (ce && sync_clr))
			bandwidth_q <= vxc_pkg::VXC_RST_BANDWIDTH;
		else if (ce && wr_data && sel_bw)
			bandwidth_q <= io_wdata & vxc_pkg::VXC_MASK_BANDWIDTH;
	end

	// preset row reset and sync reset
	always_ff @(posedge clk)
	begin
		if (srst || (ce && sync_clr))
			preset_q <= vxc_pkg::VXC_RST_PRESET;
		else if (ce && wr_data && sel_pre)
			preset_q <= io_wdata & vxc_pkg::VXC_MASK_PRESET;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rom_control_q <= vxc_pkg::VXC_RST_ROM;
			font_control_q <= vxc_pkg::VXC_RST_FONT;
			panel_control_q <= vxc_pkg::VXC_RST_PANEL;
		end
		else if (ce && wr_data)
		begin
			if (sel_rom)
				rom_control_q <= io_wdata & vxc_pkg::VXC_MASK_ROM;
			if (sel_font)
				font_control_q <= io_wdata & vxc_pkg::VXC_MASK_FONT;
			if (sel_panel)
				panel_control_q <= io_wdata & vxc_pkg::VXC_MASK_PANEL;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			io_rdata_q <= 8'h00;
			row_scan_q <= 5'h00;
		end
		else if (ce)
		begin
			if (rd_index || rd_data)
				io_rdata_q <= rd_value;
			if (frame_start)
				row_scan_q <= upper_screen_preset_row;
			else if (line_hit)
				row_scan_q <= preset_q[4:0];
			else if (line_start)
				row_scan_q <= row_next;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rom_cs_q <= 1'b0;
			rom_addr_q <= 16'h0000;
			sync_width_prog_q <= 1'b0;
			sync_width_q <= FIXED_SYNC_WIDTH;
			gray_clk_en_q <= 1'b1;
			hfb_clk_en_q <= 1'b1;
			pclk_en_q <= 1'b1;
			xtal_drive_q <= 1'b0;
			nine_dot_q <= 1'b1;
		end
		else if (ce)
		begin
			rom_cs_q <= bios_rd & ~rom_control_q[vxc_pkg::VXC_ROM_DISABLE_BIT];
			rom_addr_q <= rom_addr_d;
			sync_width_prog_q <= sync_prog;
			sync_width_q <= sync_prog ? legacy_sync_width_reg[5:0]
				: FIXED_SYNC_WIDTH;
			// power save gates data path clocks
			gray_clk_en_q <= ~power_save;
			hfb_clk_en_q <= ~power_save;
			// enable every other cycle halves the clock
			pclk_en_q <= div2 ? ~pclk_en_q : 1'b1;
			xtal_drive_q <= panel_control_q[vxc_pkg::VXC_PANEL_XTAL_BIT];
			nine_dot_q <= nine_dot;
		end
	end

	// no processor or display cycles in power save
	vxc_mem_arbiter u_arbiter (
		.clk            (clk),
		.srst           (srst),
		.ce             (ce),
		.il             (il),
		.hretrace       (hretrace),
		.vretrace       (vretrace),
		.video_on       (video_on),
		.pointer_en     (pointer_en),
		.power_save     (power_save),
		.slot_cpu_q     (slot_cpu_q),
		.slot_crt_q     (slot_crt_q),
		.slot_refresh_q (slot_refresh_q),
		.slot_pointer_q (slot_pointer_q)
	);

	vxc_font_addr u_font (
		.clk          (clk),
		.srst         (srst),
		.ce           (ce),
		.char_code    (char_code),
		.scan_row     (row_scan_q),
		.font_ptr     (font_control_q[vxc_pkg::VXC_FONT_PTR_LSB +: 3]),
		.font_pos     (font_control_q[vxc_pkg::VXC_FONT_POS_BIT]),
		.plane3       (font_control_q[vxc_pkg::VXC_FONT_PLANE3_BIT]),
		.font_addr_q  (font_addr_q),
		.font_plane_q (font_plane_q)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst || !ce);

	a_rom_ignore: assert property (
		bios_rd |=> rom_cs_q
			== !$past(rom_control_q[vxc_pkg::VXC_ROM_DISABLE_BIT]))
		else $error("BIOS read answer does not follow ROM disable");

	a_rom_page: assert property (
		bios_rd && rom_top |=> rom_addr_q[15:13] == $past(rom_page))
		else $error("ROM page not substituted in top block");

	a_preset_clear: assert property (
		sync_clr |=> preset_q == 8'h00 && bandwidth_q == 8'h00)
		else $error("sync reset did not clear preset row");

	a_row_load: assert property (
		line_hit && !frame_start |=> row_scan_q == $past(preset_q[4:0]))
		else $error("row counter not loaded on line compare");

	a_nine_force: assert property (
		cga_mga_compat_state && !half_input_clock_mode && nine_dot
			&& bw_cga_mga_compat_state == 2'h3 |-> il == vxc_pkg::VXC_IL_1_4)
		else $error("nine-dot 1:7 not forced to 1:4");

	a_half_clock: assert property (
		cga_mga_compat_state && half_input_clock_mode
			|-> il == vxc_pkg::VXC_IL_3_2)
		else $error("half clock mode not forced to 3:2");

	a_clock_halve: assert property (
		div2 ##1 div2 |-> pclk_en_q != $past(pclk_en_q))
		else $error("primary clock enable not halving");

endmodule

/* testbench/tb_vga_extension_control_regs.sv */
// Self-checking bench for the sequencer extension register group
`timescale 1ns/1ps
module tb_vga_extension_control_regs;
	logic        clk, srst, ce, io_wr, io_rd, bios_rd;
	logic [15:0] io_addr, rom_addr_q, font_addr_q;
	logic [7:0]  io_wdata, io_rdata_q, sequencer_clocking_reg;
	logic [7:0]  char_code, legacy_sync_width_reg;
	logic        sequencer_sync_reset_bit, cga_mga_compat_state;
	logic        half_input_clock_mode, hretrace, vretrace, video_on;
	logic        pointer_en, line_start, frame_start;
	logic [14:0] bios_addr;
	logic [9:0]  scan_line, line_compare_reg;
	logic [4:0]  upper_screen_preset_row, cell_height, row_scan_q;
	logic        slot_cpu_q, slot_crt_q, slot_refresh_q, slot_pointer_q;
	logic        rom_cs_q, sync_width_prog_q, gray_clk_en_q, hfb_clk_en_q;
	logic        pclk_en_q, xtal_drive_q, nine_dot_q;
	logic [1:0]  font_plane_q;
	logic [5:0]  sync_width_q;
	int          n_mismatch, compares;

	vxc_ext_regs dut (.clk(clk), .srst(srst), .ce(ce), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata_q(io_rdata_q),
		.sequencer_clocking_reg(sequencer_clocking_reg),
		.sequencer_sync_reset_bit(sequencer_sync_reset_bit),
		.cga_mga_compat_state(cga_mga_compat_state),
		.half_input_clock_mode(half_input_clock_mode),
		.hretrace(hretrace), .vretrace(vretrace), .video_on(video_on),
		.pointer_en(pointer_en), .bios_rd(bios_rd), .bios_addr(bios_addr),
		.line_start(line_start), .frame_start(frame_start),
		.scan_line(scan_line), .line_compare_reg(line_compare_reg),
		.upper_screen_preset_row(upper_screen_preset_row),
		.cell_height(cell_height), .char_code(char_code),
		.legacy_sync_width_reg(legacy_sync_width_reg),
		.slot_cpu_q(slot_cpu_q), .slot_crt_q(slot_crt_q),
		.slot_refresh_q(slot_refresh_q), .slot_pointer_q(slot_pointer_q),
		.rom_cs_q(rom_cs_q), .rom_addr_q(rom_addr_q),
		.row_scan_q(row_scan_q), .font_addr_q(font_addr_q),
		.font_plane_q(font_plane_q), .sync_width_prog_q(sync_width_prog_q),
		.sync_width_q(sync_width_q), .gray_clk_en_q(gray_clk_en_q),
		.hfb_clk_en_q(hfb_clk_en_q), .pclk_en_q(pclk_en_q),
		.xtal_drive_q(xtal_drive_q), .nine_dot_q(nine_dot_q));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp, got);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask

	// Registered outputs need two edges after the causing input
	task automatic settle();
		repeat (3) @(negedge clk);
	endtask

	task automatic do_reset();
		@(negedge clk);
		srst = 1'b1;
		repeat (6) @(negedge clk);
		srst = 1'b0;
	endtask

	// Index then data, back to back, as the port pair expects
	task automatic wr(input logic [7:0] idx, val);
		@(negedge clk);
		io_wr = 1'b1;
		io_addr = vxc_pkg::VXC_PORT_INDEX;
		io_wdata = idx;
		@(negedge clk);
		io_addr = vxc_pkg::VXC_PORT_DATA;
		io_wdata = val;
		@(negedge clk);
		io_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] idx, output logic [7:0] v);
		@(negedge clk);
		io_wr = 1'b1;
		io_addr = vxc_pkg::VXC_PORT_INDEX;
		io_wdata = idx;
		@(negedge clk);
		io_wr = 1'b0;
		io_rd = 1'b1;
		io_addr = vxc_pkg::VXC_PORT_DATA;
		@(negedge clk);
		io_rd = 1'b0;
		v = io_rdata_q;
	endtask

	task automatic t_regs();
		logic [7:0] ix[5], rs[5], mk[5], v;
		ix = '{vxc_pkg::VXC_IDX_BANDWIDTH, vxc_pkg::VXC_IDX_ROM,
			vxc_pkg::VXC_IDX_PRESET, vxc_pkg::VXC_IDX_FONT,
			vxc_pkg::VXC_IDX_PANEL};
		rs = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
		mk = '{8'h37, 8'h80, 8'h1F, 8'h7F, 8'hFF};
		for (int i = 0; i < 5; i++)
		begin
			rd(ix[i], v);
			chk("reset value", {8'h00, rs[i]}, {8'h00, v});
			wr(ix[i], 8'hFF);
			rd(ix[i], v);
			chk("writable bits", {8'h00, mk[i]}, {8'h00, v});
		end
		wr(8'h8B, 8'hFF);
		rd(8'h8B, v);
		chk("unmapped index", 16'h0000, {8'h00, v});
		do_reset();
	endtask

	task automatic t_arb();
		int nc, nt, k;
		video_on = 1'b1;
		settle();
		nc = 0;
		nt = 0;
		repeat (10)
		begin
			@(negedge clk);
			nc += int'(slot_cpu_q === 1'b1);
			nt += int'(slot_crt_q === 1'b1);
		end
		chk("cpu slots 1:4", 16'd2, nc[15:0]);
		chk("crt slots 1:4", 16'd8, nt[15:0]);
		pointer_en = 1'b1;
		hretrace = 1'b1;
		k = 0;
		while (slot_refresh_q !== 1'b1 && k < 4)
		begin
			@(negedge clk);
			k++;
		end
		for (k = 0; slot_refresh_q === 1'b1 && k < 20; k++)
			@(negedge clk);
		chk("refresh cycles", 16'd5, k[15:0]);
		for (k = 0; slot_pointer_q === 1'b1 && k < 20; k++)
			@(negedge clk);
		chk("pointer cycles", 16'd2, k[15:0]);
		chk("retrace cpu", 16'h1, {15'h0, slot_cpu_q});
		hretrace = 1'b0;
		vretrace = 1'b1;
		settle();
		nc = 0;
		repeat (10)
		begin
			@(negedge clk);
			nc += int'(slot_cpu_q === 1'b1);
		end
		chk("vretrace cpu", 16'd10, nc[15:0]);
		vretrace = 1'b0;
	endtask

	// Processor slots over 120 cycles, a multiple of every pattern period
	task automatic bw_case(input logic [7:0] bw, seq, input logic cm, hm,
		input logic [15:0] exp);
		int nc;
		sequencer_clocking_reg = seq;
		cga_mga_compat_state = cm;
		half_input_clock_mode = hm;
		wr(vxc_pkg::VXC_IDX_BANDWIDTH, bw);
		settle();
		nc = 0;
		repeat (120)
		begin
			@(negedge clk);
			nc += int'(slot_cpu_q === 1'b1);
		end
		chk("cpu slots in 120", exp, nc[15:0]);
	endtask

	task automatic t_bw();
		bw_case(8'h01, 8'h00, 1'b0, 1'b0, 16'd60);
		bw_case(8'h02, 8'h00, 1'b0, 1'b0, 16'd40);
		bw_case(8'h03, 8'h00, 1'b0, 1'b0, 16'd15);
		bw_case(8'h04, 8'h00, 1'b0, 1'b0, 16'd24);
		bw_case(8'h05, 8'h00, 1'b0, 1'b0, 16'd72);
		bw_case(8'h00, 8'h02, 1'b0, 1'b0, 16'd72);
		bw_case(8'h00, 8'h00, 1'b1, 1'b0, 16'd24);
		bw_case(8'h10, 8'h00, 1'b1, 1'b0, 16'd60);
		bw_case(8'h20, 8'h00, 1'b1, 1'b0, 16'd24);
		bw_case(8'h30, 8'h00, 1'b1, 1'b0, 16'd24);
		bw_case(8'h30, 8'h01, 1'b1, 1'b0, 16'd15);
		bw_case(8'h10, 8'h00, 1'b1, 1'b1, 16'd72);
		bw_case(8'h00, 8'h00, 1'b0, 1'b0, 16'd24);
	endtask

	task automatic t_row();
		logic [7:0] v;
		wr(vxc_pkg::VXC_IDX_PRESET, 8'h35);
		frame_start = 1'b1;
		@(negedge clk);
		frame_start = 1'b0;
		@(negedge clk);
		chk("upper preset", 16'h07, {11'h0, row_scan_q});
		scan_line = 10'h064;
		line_start = 1'b1;
		@(negedge clk);
		line_start = 1'b0;
		@(negedge clk);
		chk("lower preset", 16'h15, {11'h0, row_scan_q});
		sequencer_sync_reset_bit = 1'b0;
		settle();
		sequencer_sync_reset_bit = 1'b1;
		rd(vxc_pkg::VXC_IDX_PRESET, v);
		chk("sync reset", 16'h00, {8'h00, v});
	endtask

	task automatic t_font();
		char_code = 8'hA7;
		wr(vxc_pkg::VXC_IDX_FONT, 8'h45);
		settle();
		chk("font up", 16'hB4E0, font_addr_q);
		chk("plane 3", 16'h3, {14'h0, font_plane_q});
		chk("fixed sync", 16'h0F, {10'h0, sync_width_q});
		wr(vxc_pkg::VXC_IDX_FONT, 8'h0D);
		settle();
		chk("font down", 16'hB4FF, font_addr_q);
		chk("plane 2", 16'h2, {14'h0, font_plane_q});
		for (int b = 4; b < 6; b++)
		begin
			wr(vxc_pkg::VXC_IDX_FONT, 8'h01 << b);
			settle();
			chk("sync prog", 16'h1, {15'h0, sync_width_prog_q});
			chk("sync width", 16'h29, {10'h0, sync_width_q});
		end
	endtask

	task automatic t_rom();
		bios_rd = 1'b1;
		bios_addr = 15'h6123;
		settle();
		chk("rom answer", 16'h1, {15'h0, rom_cs_q});
		chk("page 011", 16'h6123, rom_addr_q);
		bios_addr = 15'h0123;
		settle();
		chk("low rom", 16'h0123, rom_addr_q);
		wr(vxc_pkg::VXC_IDX_PANEL, 8'h05);
		bios_addr = 15'h6123;
		settle();
		chk("page 101", 16'hA123, rom_addr_q);
		wr(vxc_pkg::VXC_IDX_ROM, 8'h80);
		settle();
		chk("rom off", 16'h0, {15'h0, rom_cs_q});
		bios_rd = 1'b0;
	endtask

	task automatic t_panel();
		logic a;
		chk("nine dot", 16'h1, {15'h0, nine_dot_q});
		wr(vxc_pkg::VXC_IDX_PANEL, 8'hD8);
		settle();
		chk("gray clk", 16'h0, {15'h0, gray_clk_en_q});
		chk("hfb clk", 16'h0, {15'h0, hfb_clk_en_q});
		chk("psave slots", 16'h0, {15'h0, slot_cpu_q | slot_crt_q});
		chk("eight dot", 16'h0, {15'h0, nine_dot_q});
		chk("crystal", 16'h1, {15'h0, xtal_drive_q});
		a = pclk_en_q;
		@(negedge clk);
		chk("clk halve", {15'h0, ~a}, {15'h0, pclk_en_q});
		ce = 1'b0;
		a = pclk_en_q;
		settle();
		chk("ce freeze", {15'h0, a}, {15'h0, pclk_en_q});
		ce = 1'b1;
	endtask

	initial
	begin
		srst = 1'b1; ce = 1'b1; io_wr = 1'b0; io_rd = 1'b0; bios_rd = 1'b0;
		io_addr = 16'h0000; io_wdata = 8'h00; sequencer_clocking_reg = 8'h00;
		char_code = 8'h00; legacy_sync_width_reg = 8'hE9;
		sequencer_sync_reset_bit = 1'b1; cga_mga_compat_state = 1'b0;
		half_input_clock_mode = 1'b0; hretrace = 1'b0; vretrace = 1'b0;
		video_on = 1'b0; pointer_en = 1'b0; line_start = 1'b0;
		frame_start = 1'b0; bios_addr = 15'h0000; scan_line = 10'h000;
		line_compare_reg = 10'h064; upper_screen_preset_row = 5'h07;
		cell_height = 5'h1F; n_mismatch = 0; compares = 0;
		do_reset();
		t_regs();
		t_font();
		t_arb();
		t_bw();
		t_row();
		t_rom();
		t_panel();
		summarize();
	end

	initial
	begin
		repeat (5000) @(posedge clk);
		n_mismatch++;
		summarize();
	end
endmodule
